// [hdl/ssel_top.v]
// sync source selector: mode control, safety cross-check, multi-source failover, ahb-lite regs
`include "ssel_map.vh"

// Notes on behaviour
// - while a remote session runs, all keypad input is blocked.
// - while the keypad is in use, remote connection attempts are refused.
// - crystal-only mode free-runs; trim value is set by software.
// - locked to a source, time comes from it and it steers the crystal.
// - enhanced crystal, analog and analog safety modes cannot be selected.
// - pulse mode takes time from the pulse train and may steer with it.
// - serial mode takes time from the serial string and may steer with it.
// - safety mode needs two valid sources before synchronizing.
// - safety mode compares time and status; any mismatch withholds sync.
// - safety pairs are satellite with serial, and pulse with serial.
// - multi-source mode watches both of its sources' status all the time.
// - a user priority picks between sources of equal status.
// - the primary is used for as long as it reports sync.
// - primary lost, switch to secondary only if the secondary reports sync.
// - satellite plus serial mode: either primary; display alternates, primary marked.
// - pulse plus serial mode: either source may be primary.
module ssel_top #(
	parameter ALT_CYC = `SSEL_ALT_MS * `SSEL_CLK_KHZ
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire [1:0]  sat_status,
	input  wire [31:0] sat_info,
	input  wire [1:0]  pls_status,
	input  wire [31:0] pls_info,
	input  wire [1:0]  ser_status,
	input  wire [31:0] ser_info,
	input  wire        keypad_press,
	input  wire        keypad_busy,
	input  wire        remote_req,
	output reg         keypad_pass,
	output reg         remote_ack,
	output reg  [1:0]  sel_source,
	output reg  [1:0]  sync_state,
	output reg         steer_en,
	output reg  [15:0] trim_out,
	output reg  [31:0] time_out,
	output reg  [1:0]  disp_tag,
	output reg         disp_primary,
	output reg         irq
);

	// every source line arrives from another board: two flops before use
	localparam SW = 2 + 32;
	reg  [3*SW+2:0] pin_meta_reg;
	reg  [3*SW+2:0] pin_sync_reg;
	wire [3*SW+2:0] pin_raw = {keypad_press, keypad_busy, remote_req,
		sat_status, sat_info, pls_status, pls_info, ser_status, ser_info};

	always @(posedge ref_clk) begin
		if (rst) begin
			pin_meta_reg <= {(3*SW+3){1'b0}};
			pin_sync_reg <= {(3*SW+3){1'b0}};
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	wire        kp_press = pin_sync_reg[3*SW+2];
	wire        kp_busy  = pin_sync_reg[3*SW+1];
	wire        rm_req   = pin_sync_reg[3*SW];
	wire [1:0]  st_sat   = pin_sync_reg[3*SW-1 -: 2];
	wire [31:0] in_sat   = pin_sync_reg[3*SW-3 -: 32];
	wire [1:0]  st_pls   = pin_sync_reg[2*SW-1 -: 2];
	wire [31:0] in_pls   = pin_sync_reg[2*SW-3 -: 32];
	wire [1:0]  st_ser   = pin_sync_reg[SW-1 -: 2];
	wire [31:0] in_ser   = pin_sync_reg[SW-3 -: 32];

	// registers
	reg  [4:0]              ctrl_reg;
	reg  [15:0]             trim_reg;
	reg  [`SSEL_IRQ_W-1:0]  irq_stat_reg;
	reg  [`SSEL_IRQ_W-1:0]  irq_mask_reg;
	reg                     session_reg;
	reg                     ever_sync_reg;
	reg                     mismatch_reg;
	reg  [1:0]              prev_src_reg;
	reg                     dp_valid_reg;
	reg                     dp_write_reg;
	reg  [7:0]              dp_addr_reg;
	reg  [25:0]             alt_cnt_reg;
	reg                     alt_phase_reg;

	wire [3:0] mode = ctrl_reg[`SSEL_CTRL_MODE];
	wire       prio = ctrl_reg[`SSEL_CTRL_PRIO];

	// ahb-lite: zero wait states, write data lands in the data phase
	wire ap_take = hsel & htrans[1] & hready;
	wire wr_en   = dp_valid_reg & dp_write_reg;

	wire [3:0] wr_mode = hwdata[3:0];
	wire mode_bad = (wr_mode == `SSEL_MODE_ENH) | (wr_mode == `SSEL_MODE_ANALOG) |
		(wr_mode == `SSEL_MODE_ANA_SAFE) | (wr_mode > `SSEL_MODE_MS_PLS);
	wire wr_ctrl  = wr_en & (dp_addr_reg == `SSEL_OFS_CTRL);
	wire wr_trim  = wr_en & (dp_addr_reg == `SSEL_OFS_TRIM);
	wire wr_clr   = wr_en & (dp_addr_reg == `SSEL_OFS_IRQ_STAT);
	wire wr_mask  = wr_en & (dp_addr_reg == `SSEL_OFS_IRQ_MASK);

	// source choice
	reg  [1:0] cand_src;
	reg  [1:0] prim_src;
	reg  [1:0] sec_src;
	reg  [1:0] prim_st;
	reg  [1:0] sec_st;
	reg        safety_bad;
	reg [31:0] prim_info;
	reg [31:0] sec_info;

	always @* begin
		cand_src   = `SSEL_SRC_NONE;
		prim_src   = `SSEL_SRC_NONE;
		sec_src    = `SSEL_SRC_NONE;
		prim_st    = `SSEL_ST_INVALID;
		sec_st     = `SSEL_ST_INVALID;
		prim_info  = 32'h0000_0000;
		sec_info   = 32'h0000_0000;
		safety_bad = 1'b0;
		case (mode)
		`SSEL_MODE_SAT: begin
			if (st_sat == `SSEL_ST_SYNC) cand_src = `SSEL_SRC_SAT;
		end
		`SSEL_MODE_PULSE: begin
			if (st_pls == `SSEL_ST_SYNC) cand_src = `SSEL_SRC_PLS;
		end
		`SSEL_MODE_SERIAL: begin
			if (st_ser == `SSEL_ST_SYNC) cand_src = `SSEL_SRC_SER;
		end
		`SSEL_MODE_SAT_SAFE, `SSEL_MODE_PLS_SAFE: begin
			// radio source paired with the serial string
			prim_st   = (mode == `SSEL_MODE_SAT_SAFE) ? st_sat : st_pls;
			prim_info = (mode == `SSEL_MODE_SAT_SAFE) ? in_sat : in_pls;
			if (prim_st == `SSEL_ST_SYNC && st_ser == `SSEL_ST_SYNC) begin
				if (prim_info == in_ser)
					cand_src = (mode == `SSEL_MODE_SAT_SAFE) ? `SSEL_SRC_SAT : `SSEL_SRC_PLS;
				else
					safety_bad = 1'b1;
			end
		end
		`SSEL_MODE_MS_SAT, `SSEL_MODE_MS_PLS: begin
			// both statuses evaluated every cycle, whichever is in use
			if (prio) begin
				prim_src = `SSEL_SRC_SER;
				prim_st  = st_ser;
				sec_src  = (mode == `SSEL_MODE_MS_SAT) ? `SSEL_SRC_SAT : `SSEL_SRC_PLS;
				sec_st   = (mode == `SSEL_MODE_MS_SAT) ? st_sat : st_pls;
			end else begin
				prim_src = (mode == `SSEL_MODE_MS_SAT) ? `SSEL_SRC_SAT : `SSEL_SRC_PLS;
				prim_st  = (mode == `SSEL_MODE_MS_SAT) ? st_sat : st_pls;
				sec_src  = `SSEL_SRC_SER;
				sec_st   = st_ser;
			end
			// primary wins ties and is taken back as soon as it syncs
			if (prim_st == `SSEL_ST_SYNC)
				cand_src = prim_src;
			else if (sec_st == `SSEL_ST_SYNC)
				cand_src = sec_src;
		end
		default: cand_src = `SSEL_SRC_NONE; // crystal free-runs
		endcase
	end

	reg [31:0] cand_info;
	always @* begin
		case (cand_src)
		`SSEL_SRC_SAT: cand_info = in_sat;
		`SSEL_SRC_PLS: cand_info = in_pls;
		`SSEL_SRC_SER: cand_info = in_ser;
		default:       cand_info = 32'h0000_0000;
		endcase
	end

	wire is_multi = (mode == `SSEL_MODE_MS_SAT) | (mode == `SSEL_MODE_MS_PLS);
	wire failover = is_multi & (cand_src != `SSEL_SRC_NONE) & (cand_src == sec_src) &
		(prev_src_reg != sec_src);
	wire returned = is_multi & (cand_src != `SSEL_SRC_NONE) & (cand_src == prim_src) &
		(prev_src_reg == sec_src);

	// session interlock: whoever holds the panel keeps it
	wire remote_grant = rm_req & (session_reg | ~kp_busy);
	wire refused_ev   = rm_req & ~session_reg & kp_busy;
	wire blocked_ev   = kp_press & session_reg;

	wire [`SSEL_IRQ_W-1:0] irq_ev;
	assign irq_ev[`SSEL_IRQ_FAILOVER] = failover;
	assign irq_ev[`SSEL_IRQ_RETURN]   = returned;
	assign irq_ev[`SSEL_IRQ_MISMATCH] = safety_bad & ~mismatch_reg;
	assign irq_ev[`SSEL_IRQ_REJECT]   = wr_ctrl & mode_bad;
	assign irq_ev[`SSEL_IRQ_REFUSED]  = refused_ev & ~remote_ack;
	assign irq_ev[`SSEL_IRQ_BLOCKED]  = blocked_ev;

	reg [`SSEL_IRQ_W-1:0] irq_stat_next;
	always @* begin
		irq_stat_next = irq_stat_reg;
		if (wr_clr)
			irq_stat_next = irq_stat_next & ~hwdata[`SSEL_IRQ_W-1:0];
		// an event in the clearing cycle survives
		irq_stat_next = irq_stat_next | irq_ev;
	end

	// read mux, sampled in the address phase
	reg [31:0] rd_next;
	always @* begin
		case (haddr)
		`SSEL_OFS_CTRL:     rd_next = {27'h000_0000, ctrl_reg};
		`SSEL_OFS_TRIM:     rd_next = {16'h0000, trim_reg};
		`SSEL_OFS_STATUS:   rd_next = {24'h00_0000, mismatch_reg, session_reg,
			ever_sync_reg, 1'b0, sync_state, sel_source};
		`SSEL_OFS_IRQ_STAT: rd_next = {26'h000_0000, irq_stat_reg};
		`SSEL_OFS_IRQ_MASK: rd_next = {26'h000_0000, irq_mask_reg};
		`SSEL_OFS_TIME:     rd_next = time_out;
		default:            rd_next = 32'h0000_0000;
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg  <= 8'h00;
			hrdata       <= 32'h0000_0000;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			ctrl_reg     <= `SSEL_CTRL_RST;
			trim_reg     <= `SSEL_TRIM_RST;
			irq_stat_reg <= {`SSEL_IRQ_W{1'b0}};
			irq_mask_reg <= {`SSEL_IRQ_W{1'b0}};
			irq          <= 1'b0;
		end else begin
			dp_valid_reg <= ap_take;
			dp_write_reg <= hwrite;
			dp_addr_reg  <= haddr;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			if (ap_take & ~hwrite)
				hrdata <= rd_next;
			if (wr_ctrl) begin
				ctrl_reg[`SSEL_CTRL_PRIO] <= hwdata[`SSEL_CTRL_PRIO];
				if (!mode_bad)
					ctrl_reg[`SSEL_CTRL_MODE] <= wr_mode;
			end
			if (wr_trim)
				trim_reg <= hwdata[15:0];
			if (wr_mask)
				irq_mask_reg <= hwdata[`SSEL_IRQ_W-1:0];
			irq_stat_reg <= irq_stat_next;
			irq          <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// timing core and operator panel
	always @(posedge ref_clk) begin
		if (rst) begin
			session_reg   <= 1'b0;
			keypad_pass   <= 1'b0;
			remote_ack    <= 1'b0;
			sel_source    <= `SSEL_SRC_NONE;
			prev_src_reg  <= `SSEL_SRC_NONE;
			sync_state    <= `SSEL_ST_INVALID;
			steer_en      <= 1'b0;
			trim_out      <= `SSEL_TRIM_RST;
			time_out      <= 32'h0000_0000;
			ever_sync_reg <= 1'b0;
			mismatch_reg  <= 1'b0;
		end else begin
			session_reg  <= remote_grant;
			remote_ack   <= remote_grant;
			keypad_pass  <= kp_press & ~session_reg & ~remote_grant;
			sel_source   <= cand_src;
			prev_src_reg <= cand_src;
			mismatch_reg <= safety_bad;
			trim_out     <= trim_reg;
			steer_en     <= (cand_src != `SSEL_SRC_NONE);
			if (cand_src != `SSEL_SRC_NONE) begin
				time_out      <= cand_info;
				ever_sync_reg <= 1'b1;
				sync_state    <= `SSEL_ST_SYNC;
			end else if (ever_sync_reg || mode == `SSEL_MODE_CRYSTAL) begin
				sync_state    <= `SSEL_ST_CRYSTAL;
			end else begin
				sync_state    <= `SSEL_ST_INVALID;
			end
		end
	end

	// display: multi-source modes alternate the two tags, primary marked
	always @(posedge ref_clk) begin
		if (rst) begin
			alt_cnt_reg   <= 26'h000_0000;
			alt_phase_reg <= 1'b0;
			disp_tag      <= `SSEL_SRC_NONE;
			disp_primary  <= 1'b0;
		end else begin
			if (alt_cnt_reg >= ALT_CYC[25:0] - 26'h000_0001) begin
				alt_cnt_reg   <= 26'h000_0000;
				alt_phase_reg <= ~alt_phase_reg;
			end else begin
				alt_cnt_reg <= alt_cnt_reg + 26'h000_0001;
			end
			if (is_multi) begin
				disp_tag     <= alt_phase_reg ? sec_src : prim_src;
				disp_primary <= ~alt_phase_reg;
			end else begin
				disp_tag     <= cand_src;
				disp_primary <= 1'b0;
			end
		end
	end

endmodule // ssel_top

// [hdl/ssel_map.vh]
// register map, field positions, codes and timing counts of the sync source selector
`ifndef SSEL_MAP_VH
`define SSEL_MAP_VH

`define SSEL_OFS_CTRL      8'h00
`define SSEL_OFS_TRIM      8'h04
`define SSEL_OFS_STATUS    8'h08
`define SSEL_OFS_IRQ_STAT  8'h0C
`define SSEL_OFS_IRQ_MASK  8'h10
`define SSEL_OFS_TIME      8'h14

`define SSEL_CTRL_MODE     3:0
`define SSEL_CTRL_PRIO     4
`define SSEL_CTRL_RST      5'h00
`define SSEL_TRIM_RST      16'h8000

`define SSEL_MODE_CRYSTAL  4'h0
`define SSEL_MODE_ENH      4'h1
`define SSEL_MODE_SAT      4'h2
`define SSEL_MODE_PULSE    4'h3
`define SSEL_MODE_SERIAL   4'h4
`define SSEL_MODE_ANALOG   4'h5
`define SSEL_MODE_SAT_SAFE 4'h6
`define SSEL_MODE_PLS_SAFE 4'h7
`define SSEL_MODE_ANA_SAFE 4'h8
`define SSEL_MODE_MS_SAT   4'h9
`define SSEL_MODE_MS_PLS   4'hA

`define SSEL_SRC_NONE      2'h0
`define SSEL_SRC_SAT       2'h1
`define SSEL_SRC_PLS       2'h2
`define SSEL_SRC_SER       2'h3

`define SSEL_ST_INVALID    2'h0
`define SSEL_ST_CRYSTAL    2'h1
`define SSEL_ST_SYNC       2'h2

`define SSEL_IRQ_FAILOVER  0
`define SSEL_IRQ_RETURN    1
`define SSEL_IRQ_MISMATCH  2
`define SSEL_IRQ_REJECT    3
`define SSEL_IRQ_REFUSED   4
`define SSEL_IRQ_BLOCKED   5
`define SSEL_IRQ_W         6

`define SSEL_ALT_MS        1000
`define SSEL_CLK_KHZ       40000

`endif

// [sim/ssel_properties.sv]
// assertion checker for the sync source selector, bound to its top module
`include "ssel_map.vh"
module ssel_chk #(
	parameter ALT_CYC = 8
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [31:0] sat_info,
	input wire logic [1:0]  sat_status,
	input wire logic [1:0]  ser_status,
	input wire logic        keypad_busy,
	input wire logic        remote_req,
	input wire logic        keypad_pass,
	input wire logic        remote_ack,
	input wire logic [1:0]  sel_source,
	input wire logic [1:0]  sync_state,
	input wire logic        steer_en,
	input wire logic [31:0] time_out,
	input wire logic        disp_primary
);
	// slack of a few cycles on top of one display phase
	localparam int alt_max = ALT_CYC + 4;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_keypad_blocked: assert property (
		remote_ack |-> !keypad_pass) else $error("keypad passed in session");
	a_session_holds: assert property (
		remote_ack ##1 $past(remote_req, 3) |-> remote_ack) else $error("session dropped");
	a_remote_refused: assert property (
		$rose(remote_ack) |-> !$past(keypad_busy, 3)) else $error("session granted to busy panel");
	a_idle_no_steer: assert property (
		sel_source == `SSEL_SRC_NONE |-> !steer_en && sync_state != `SSEL_ST_SYNC)
		else $error("no source but steering or sync");
	a_steer_locked: assert property (
		steer_en |-> sync_state == `SSEL_ST_SYNC && sel_source != `SSEL_SRC_NONE)
		else $error("steering without lock");
	a_time_follow: assert property (
		(sel_source == `SSEL_SRC_SAT) [*2] ##0 $past(sat_info, 2) == $past(sat_info, 4)
		|-> time_out == $past(sat_info, 3)) else $error("time not from selected source");
	a_switch_sync: assert property (
		$changed(sel_source) && $past(sel_source) != `SSEL_SRC_NONE
		&& sel_source != `SSEL_SRC_NONE |-> sync_state == `SSEL_ST_SYNC
		&& (sel_source != `SSEL_SRC_SER || $past(ser_status, 3) == `SSEL_ST_SYNC)
		&& (sel_source != `SSEL_SRC_SAT || $past(sat_status, 3) == `SSEL_ST_SYNC))
		else $error("switched to unsynced source");
	a_disp_alt: assert property (
		$rose(disp_primary) |-> ##[1:alt_max] !disp_primary) else $error("display not alternating");
	cover property ($fell(sel_source == `SSEL_SRC_SAT) && sel_source == `SSEL_SRC_SER);
	cover property ($rose(remote_ack));
	cover property ($rose(disp_primary));
endmodule // ssel_chk

bind ssel_top ssel_chk #(.ALT_CYC(ALT_CYC)) u_chk (.*);

// [sim/ssel_src_model.sv]
// behavioural model of the three sync receiver boards
module ssel_src_model (
	input  wire logic        ref_clk,
	output logic [1:0]  sat_status,
	output logic [1:0]  pls_status,
	output logic [1:0]  ser_status,
	output logic [31:0] sat_info,
	output logic [31:0] pls_info,
	output logic [31:0] ser_info
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{sat_status, pls_status, ser_status} = 6'h0;
		{sat_info, pls_info, ser_info} = 96'h0;
	end
	task automatic put(input logic [1:0] a, b, c);
		@(posedge ref_clk);
		sat_status <= a;
		pls_status <= b;
		ser_status <= c;
	endtask
	// words are held until the next update: the selector resyncs bit by bit
	task automatic info(input logic [31:0] a, b, c);
		@(posedge ref_clk);
		sat_info <= a;
		pls_info <= b;
		ser_info <= c;
	endtask
endmodule // ssel_src_model

// [sim/tb.sv]
// self-checking bench for the sync source selector
`include "ssel_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] ns = `SSEL_SRC_NONE, sa = `SSEL_SRC_SAT, pu = `SSEL_SRC_PLS;
	localparam logic [1:0] se = `SSEL_SRC_SER, iv = `SSEL_ST_INVALID, cr = `SSEL_ST_CRYSTAL;
	localparam logic [1:0] sy = `SSEL_ST_SYNC;
	localparam logic [31:0] ka = 32'h1111_0000, kb = 32'h2222_0000, kc = 32'h3333_0000;
	localparam logic [31:0] rj [3] = '{32'h1, 32'h5, 32'h8};
	logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, irq, steer_en;
	logic        keypad_press, keypad_busy, remote_req, keypad_pass, remote_ack, disp_primary;
	logic [7:0]  haddr;
	logic [1:0]  htrans, sel_source, sync_state, disp_tag, pt, st;
	logic [1:0]  sat_status, pls_status, ser_status;
	logic [15:0] trim_out;
	logic [31:0] hwdata, hrdata, time_out, sat_info, pls_info, ser_info;
	logic [31:0] inf [4];
	int          error_cnt, num_checks, n;

	ssel_top #(.ALT_CYC(8)) dut (.*, .hsize(3'h2), .hready(hreadyout));
	ssel_src_model src (.*);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// no fixed wait state is assumed: poll ready under a bound
	task automatic hold;
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH t=%0t bus ready timeout", $time);
			wrap_up();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hold();
		htrans <= 2'h0;
		hwdata <= d;
		hold();
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	task automatic si(input logic [31:0] a, b, c);
		inf = '{32'h0, a, b, c};
		src.info(a, b, c);
	endtask
	task automatic sc(input logic [31:0] c, input logic [1:0] a, b, s, es, ey);
		src.put(a, b, s);
		wr(`SSEL_OFS_CTRL, c);
		repeat (6) @(posedge ref_clk);
		chk(32'(sel_source), 32'(es));
		chk(32'(sync_state), 32'(ey));
		chk(32'(steer_en), 32'(ey == sy));
		if (es != ns)
			chk(time_out, inf[es]);
	endtask
	task automatic pins(input logic q, b, p);
		@(posedge ref_clk);
		remote_req <= q;
		keypad_busy <= b;
		keypad_press <= p;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic ic(input logic e);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'(e));
	endtask

	initial begin
		{rst, hsel, hwrite, keypad_press, keypad_busy, remote_req} = 6'h20;
		{haddr, htrans, hwdata} = 42'h0;
		error_cnt = 0;
		num_checks = 0;
		inf = '{32'h0, 32'h0, 32'h0, 32'h0};
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rc(`SSEL_OFS_CTRL, 32'h0);
		rc(`SSEL_OFS_TRIM, 32'h8000);
		rc(`SSEL_OFS_STATUS, 32'h4);
		rc(`SSEL_OFS_IRQ_MASK, 32'h0);
		rc(8'h20, 32'h0);
		wr(`SSEL_OFS_TRIM, 32'h1234);
		rc(`SSEL_OFS_TRIM, 32'h1234);
		chk(32'(trim_out), 32'h1234);
		chk(32'(hresp), 32'h0);
		$display("test registers done");
		wr(`SSEL_OFS_CTRL, 32'h2);
		rc(`SSEL_OFS_STATUS, 32'h0);
		foreach (rj[i]) begin
			wr(`SSEL_OFS_CTRL, rj[i]);
			rc(`SSEL_OFS_CTRL, 32'h2);
		end
		rc(`SSEL_OFS_IRQ_STAT, 32'h8);
		ic(1'b0);
		wr(`SSEL_OFS_IRQ_MASK, 32'h8);
		ic(1'b1);
		wr(`SSEL_OFS_IRQ_STAT, 32'h8);
		ic(1'b0);
		$display("test rejected modes done");
		si(ka, kb, kc);
		sc(32'h2, sy, sy, sy, sa, sy);
		sc(32'h3, sy, sy, sy, pu, sy);
		sc(32'h4, sy, sy, sy, se, sy);
		sc(32'h4, sy, sy, cr, ns, cr);
		sc(32'h0, sy, sy, sy, ns, cr);
		$display("test single source done");
		si(ka, kb, ka);
		sc(32'h6, sy, sy, sy, sa, sy);
		sc(32'h6, sy, sy, cr, ns, cr);
		sc(32'h7, sy, sy, sy, ns, cr);
		si(ka, ka, ka);
		sc(32'h7, sy, sy, sy, pu, sy);
		wr(`SSEL_OFS_IRQ_STAT, 32'h3F);
		si(ka, ka, kc);
		sc(32'h7, sy, sy, sy, ns, cr);
		rc(`SSEL_OFS_IRQ_STAT, 32'h4);
		$display("test safety done");
		si(ka, kb, kc);
		sc(32'h9, sy, iv, sy, sa, sy);
		wr(`SSEL_OFS_IRQ_STAT, 32'h3F);
		sc(32'h9, cr, iv, sy, se, sy);
		sc(32'h9, sy, iv, sy, sa, sy);
		rc(`SSEL_OFS_IRQ_STAT, 32'h3);
		sc(32'h9, iv, iv, cr, ns, cr);
		sc(32'h19, sy, iv, sy, se, sy);
		pt = ns;
		st = ns;
		for (n = 0; n < 40; n++) begin
			@(posedge ref_clk);
			if (disp_primary === 1'b1)
				pt = disp_tag;
			else
				st = disp_tag;
		end
		chk(32'(pt), 32'(se));
		chk(32'(st), 32'(sa));
		sc(32'hA, iv, sy, sy, pu, sy);
		sc(32'h1A, iv, sy, sy, se, sy);
		$display("test multi source done");
		wr(`SSEL_OFS_IRQ_STAT, 32'h3F);
		pins(1'b1, 1'b1, 1'b0);
		chk(32'(remote_ack), 32'h0);
		pins(1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b0, 1'b0);
		chk(32'(remote_ack), 32'h1);
		pins(1'b1, 1'b1, 1'b1);
		chk(32'(remote_ack), 32'h1);
		chk(32'(keypad_pass), 32'h0);
		pins(1'b0, 1'b1, 1'b1);
		chk(32'(keypad_pass), 32'h1);
		rc(`SSEL_OFS_IRQ_STAT, 32'h30);
		$display("test panel interlock done");
		wrap_up();
	end
endmodule // tb
